//--- ebt_defines.svh
// register offsets, field positions, reset values of the 8-bit dual channel timer
// assumes inclusion by bare name from the timer module and its bench
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_OFF_COUNT 8'hca
`define EBT_OFF_CTL 8'hcb
`define EBT_OFF_CCTL0 8'hcc
`define EBT_OFF_CC0 8'hcd
`define EBT_OFF_CCTL1 8'hce
`define EBT_OFF_CC1 8'hcf
`define EBT_CTL_DIV_HI 7
`define EBT_CTL_DIV_LO 5
`define EBT_CTL_START 4
`define EBT_CTL_TERMINAL_COUNT_IRQ_MASK 3
`define EBT_CTL_CLR 2
`define EBT_CTL_MODE_HI 1
`define EBT_CTL_MODE_LO 0
`define EBT_CCTL_IM 6
`define EBT_CCTL_ACT_HI 5
`define EBT_CCTL_ACT_LO 3
`define EBT_CCTL_EN 2
`define EBT_CTL_RESET 8'h08
`define EBT_CCTL_RESET 8'h40
`define EBT_CNT_ZERO 8'h00
`define EBT_CNT_MAX 8'hff
`endif

//--- ebt_pkg.sv
// types shared by the 8-bit dual channel timer
// assumes ebt_defines.svh for numeric constants
`default_nettype none
package ebt_pkg;
  typedef enum logic [1:0] {
    EBT_FREE = 2'b00,
    EBT_DOWN = 2'b01,
    EBT_MODULO = 2'b10,
    EBT_UPDOWN = 2'b11
  } ebt_mode_t;
  typedef enum logic [2:0] {
    EBT_SET = 3'b000,
    EBT_CLEAR = 3'b001,
    EBT_TOGGLE = 3'b010,
    EBT_UPSET = 3'b011,
    EBT_UPCLEAR = 3'b100,
    EBT_SETREV = 3'b101,
    EBT_CLEARREV = 3'b110,
    EBT_UNUSED = 3'b111
  } ebt_act_t;
  typedef struct packed {
    logic [2:0] div;
    logic start;
    logic terminal_count_irq_mask;
    ebt_mode_t mode;
  } ebt_ctl_t;
  typedef struct packed {
    logic im;
    ebt_act_t act;
    logic en;
  } ebt_chan_t;
endpackage
`default_nettype wire

//--- ebt_timer.sv
// 8-bit timer with two output-compare channels, one instance per timer
// assumes sfr strobes and tickEn come from logic on core_clk
// Functional notes
// - prescaler divides tick by 1 to 128
// - start bit runs, clearing it halts
// - clear bit zeroes counter, reads zero
// - clear also restores counting up
// - mode field selects four counting modes
// - free mode wraps at 0xff, flags
// - down mode loads compare 0, counts down
// - modulo mode wraps at compare 0
// - up/down mode bounces between zero, compare
// - terminal count irq gated by mask
// - enabled channels act on compare match
// - channel outputs are glitch free
// - compare 0 applies at zero, 1 immediately
// - match sets channel flag, masked irq
// - one irq line per timer instance
// - unmasking a set flag requests again
// - no new request until flag cleared
// - one dma pulse per channel match
// - count register reads current value
// - seven compare output action codes, code 7 unused
// - compare disabled, mask set after reset
`include "ebt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ebt_timer
  import ebt_pkg::*;
#(
  parameter logic [3:0] IRQ_LINE = 4'd11
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tickEn,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic [2:0] flagClr,
  output logic tcFlag,
  output logic [1:0] chFlag,
  output logic irqReq,
  output logic [3:0] irqLine,
  output logic [1:0] chOut,
  output logic [1:0] dmaTrig
);
  ebt_ctl_t ctl, next_ctl;
  ebt_chan_t ch [2];
  ebt_chan_t next_ch [2];
  logic [7:0] cnt, next_cnt, cc0Buf, next_cc0Buf, cc0Act, next_cc0Act, cc1, next_cc1;
  logic [6:0] pre, next_pre, divMask;
  logic dirUp, next_dirUp, next_tcFlag, next_irqReq;
  logic [1:0] next_chFlag, next_chOut, next_dmaTrig, match;
  logic [2:0] pending, pendPrev;
  logic [7:0] next_rd;
  logic wrCtl, activeEdge, run, tcEv, countUp;

  assign wrCtl = sfrWrEn && sfrAddr == `EBT_OFF_CTL;
  assign divMask = 7'((8'h01 << ctl.div) - 8'h01);
  assign activeEdge = tickEn && ((pre & divMask) == divMask);
  assign run = ctl.start && activeEdge;
  assign countUp = !(ctl.mode == EBT_UPDOWN && !dirUp);
  assign pending = {chFlag[1] & ch[1].im, chFlag[0] & ch[0].im, tcFlag & ctl.terminal_count_irq_mask};

  always_comb begin
    logic [7:0] ccv;
    logic revEv;
    logic zeroEv;
    ccv = 8'h00;
    revEv = 1'b0;
    zeroEv = 1'b0;
    next_ctl = ctl;
    next_ch = ch;
    next_cnt = cnt;
    next_cc0Buf = cc0Buf;
    next_cc0Act = cc0Act;
    next_cc1 = cc1;
    next_dirUp = dirUp;
    next_chOut = chOut;
    match = 2'b00;
    tcEv = 1'b0;
    next_pre = tickEn ? 7'(pre + 7'd1) : pre;
    if (cnt == `EBT_CNT_ZERO) begin
      next_cc0Act = cc0Buf;
    end
    if (run) begin
      case (ctl.mode)
        EBT_DOWN: begin
          if (cnt == `EBT_CNT_ZERO) begin
            next_cnt = cc0Act;
          end else begin
            next_cnt = 8'(cnt - 8'd1);
            tcEv = cnt == 8'd1;
          end
        end
        EBT_MODULO: begin
          if (cnt == cc0Act) begin
            next_cnt = `EBT_CNT_ZERO;
            tcEv = 1'b1;
          end else begin
            next_cnt = 8'(cnt + 8'd1);
          end
        end
        EBT_UPDOWN: begin
          if (dirUp) begin
            if (cnt >= cc0Act) begin
              next_dirUp = 1'b0;
              next_cnt = (cnt == `EBT_CNT_ZERO) ? cnt : 8'(cnt - 8'd1);
            end else begin
              next_cnt = 8'(cnt + 8'd1);
            end
          end else if (cnt == `EBT_CNT_ZERO) begin
            next_dirUp = 1'b1;
            next_cnt = 8'(cnt + 8'd1);
          end else begin
            next_cnt = 8'(cnt - 8'd1);
            tcEv = cnt == 8'd1;
          end
        end
        default: begin
          next_cnt = 8'(cnt + 8'd1);
          tcEv = cnt == `EBT_CNT_MAX;
        end
      endcase
      // outputs change only at the clock edge, never through a gate path
      for (int i = 0; i < 2; i++) begin
        ccv = (i == 0) ? cc0Act : cc1;
        revEv = (i == 0) ? (cnt == `EBT_CNT_MAX) : (cnt == cc0Act);
        zeroEv = ch[i].en && cnt == `EBT_CNT_ZERO;
        match[i] = ch[i].en && cnt == ccv;
        if (!ch[i].en) begin
          revEv = 1'b0;
        end
        case (ch[i].act)
          EBT_SET: if (match[i]) next_chOut[i] = 1'b1;
          EBT_CLEAR: if (match[i]) next_chOut[i] = 1'b0;
          EBT_TOGGLE: if (match[i]) next_chOut[i] = ~chOut[i];
          EBT_UPSET: begin
            if (match[i]) next_chOut[i] = countUp;
            else if (zeroEv) next_chOut[i] = 1'b0;
          end
          EBT_UPCLEAR: begin
            if (match[i]) next_chOut[i] = !countUp;
            else if (zeroEv) next_chOut[i] = 1'b1;
          end
          EBT_SETREV: begin
            if (match[i]) next_chOut[i] = 1'b1;
            else if (revEv) next_chOut[i] = 1'b0;
          end
          EBT_CLEARREV: begin
            if (match[i]) next_chOut[i] = 1'b0;
            else if (revEv) next_chOut[i] = 1'b1;
          end
          default: next_chOut[i] = chOut[i];
        endcase
      end
    end
    if (sfrWrEn) begin
      case (sfrAddr)
        `EBT_OFF_CTL: begin
          next_ctl.div = sfrWrData[`EBT_CTL_DIV_HI:`EBT_CTL_DIV_LO];
          next_ctl.start = sfrWrData[`EBT_CTL_START];
          next_ctl.terminal_count_irq_mask = sfrWrData[`EBT_CTL_TERMINAL_COUNT_IRQ_MASK];
          next_ctl.mode = ebt_mode_t'(sfrWrData[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO]);
          if (sfrWrData[`EBT_CTL_START] && !ctl.start &&
              sfrWrData[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO] == EBT_DOWN) begin
            next_cnt = cc0Act;
          end
          if (sfrWrData[`EBT_CTL_CLR]) begin
            next_cnt = `EBT_CNT_ZERO;
            next_dirUp = 1'b1;
          end
        end
        `EBT_OFF_CCTL0, `EBT_OFF_CCTL1: begin
          next_ch[sfrAddr[1]].im = sfrWrData[`EBT_CCTL_IM];
          next_ch[sfrAddr[1]].act = ebt_act_t'(sfrWrData[`EBT_CCTL_ACT_HI:`EBT_CCTL_ACT_LO]);
          next_ch[sfrAddr[1]].en = sfrWrData[`EBT_CCTL_EN];
        end
        `EBT_OFF_CC0: next_cc0Buf = sfrWrData;
        `EBT_OFF_CC1: next_cc1 = sfrWrData;
        default: next_cc1 = cc1;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    next_tcFlag = (tcFlag & ~flagClr[0]) | tcEv;
    next_chFlag = (chFlag & ~flagClr[2:1]) | match;
    // request on a rising masked flag: covers unmasking and needs a clear to recur
    next_irqReq = |(pending & ~pendPrev);
    next_dmaTrig = match;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl <= ebt_ctl_t'({3'b000, 1'b0, 1'b1, EBT_FREE});
      ch[0] <= ebt_chan_t'({1'b1, EBT_SET, 1'b0});
      ch[1] <= ebt_chan_t'({1'b1, EBT_SET, 1'b0});
      cnt <= `EBT_CNT_ZERO;
      cc0Buf <= 8'h00;
      cc0Act <= 8'h00;
      cc1 <= 8'h00;
      pre <= 7'h00;
      dirUp <= 1'b1;
      tcFlag <= 1'b0;
      chFlag <= 2'b00;
      pendPrev <= 3'b000;
      irqReq <= 1'b0;
      irqLine <= IRQ_LINE;
      chOut <= 2'b00;
      dmaTrig <= 2'b00;
    end else begin
      ctl <= next_ctl;
      ch <= next_ch;
      cnt <= next_cnt;
      cc0Buf <= next_cc0Buf;
      cc0Act <= next_cc0Act;
      cc1 <= next_cc1;
      pre <= next_pre;
      dirUp <= next_dirUp;
      tcFlag <= next_tcFlag;
      chFlag <= next_chFlag;
      pendPrev <= pending;
      irqReq <= next_irqReq;
      irqLine <= IRQ_LINE;
      chOut <= next_chOut;
      dmaTrig <= next_dmaTrig;
    end
  end

  always_comb begin
    next_rd = 8'h00;
    if (sfrRdEn) begin
      case (sfrAddr)
        `EBT_OFF_COUNT: next_rd = cnt;
        `EBT_OFF_CTL: next_rd = {ctl.div, ctl.start, ctl.terminal_count_irq_mask, 1'b0, ctl.mode};
        `EBT_OFF_CCTL0: next_rd = {1'b0, ch[0].im, ch[0].act, ch[0].en, 2'b00};
        `EBT_OFF_CC0: next_rd = cc0Buf;
        `EBT_OFF_CCTL1: next_rd = {1'b0, ch[1].im, ch[1].act, ch[1].en, 2'b00};
        `EBT_OFF_CC1: next_rd = cc1;
        default: next_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfrRdData <= 8'h00;
    end else begin
      sfrRdData <= next_rd;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_clear_zeroes: assert property (wrCtl && sfrWrData[`EBT_CTL_CLR] |=> cnt == 8'h00 && dirUp)
    else $error("counter clear did not zero the count");
  a_halt_holds: assert property (!ctl.start && !wrCtl |=> cnt == $past(cnt))
    else $error("halted counter moved");
  a_free_wrap: assert property (run && ctl.mode == EBT_FREE && cnt == 8'hff && !wrCtl
      |=> cnt == 8'h00 && tcFlag)
    else $error("free mode did not wrap with flag");
  a_modulo_wrap: assert property (run && ctl.mode == EBT_MODULO && cnt == cc0Act && !wrCtl
      |=> cnt == 8'h00 && tcFlag)
    else $error("modulo mode did not wrap at compare");
  a_irq_cause: assert property (irqReq |-> $past(|pending))
    else $error("irq request without masked flag");
  a_irq_rise: assert property ($rose(pending[0]) |=> irqReq)
    else $error("rising masked flag gave no request");
  a_cc1_now: assert property (sfrWrEn && sfrAddr == `EBT_OFF_CC1 |=> cc1 == $past(sfrWrData))
    else $error("channel 1 compare not applied at once");
  a_cc0_defer: assert property (cnt != 8'h00 |=> cc0Act == $past(cc0Act))
    else $error("channel 0 compare changed away from zero");
  a_dma_cause: assert property (dmaTrig[0] |-> $past(ch[0].en && run))
    else $error("dma pulse without enabled match");
  a_set_match: assert property (match[0] && ch[0].act == EBT_SET |=> chOut[0])
    else $error("set action did not raise output");
  a_clr_reads: assert property (sfrRdEn && sfrAddr == `EBT_OFF_CTL |=> !sfrRdData[`EBT_CTL_CLR])
    else $error("clear bit read back as one");
  c_free_wrap: cover property (run && ctl.mode == EBT_FREE && cnt == 8'hff);
  c_updown_turn: cover property (run && ctl.mode == EBT_UPDOWN && dirUp ##1 !dirUp);
  c_irq: cover property (irqReq);
  c_dma_both: cover property (dmaTrig[0] ##[1:600] dmaTrig[1]);
endmodule
`default_nettype wire

//--- ebt_tick_src.sv
// tick source standing in for the system tick divider
// assumes it shares core_clk and rst with the timer
`timescale 1ns/1ps
`default_nettype none
module ebt_tick_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] num,
  input wire logic go,
  output logic tickEn,
  output logic busy
);
  logic [9:0] left;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      left <= 10'h000;
      tickEn <= 1'b0;
    end else if (go) begin
      left <= num;
      tickEn <= 1'b0;
    end else begin
      // gap after each tick so a window of n ticks is exact
      tickEn <= (left != 10'h000) && !tickEn;
      if (left != 10'h000 && !tickEn) begin
        left <= left - 10'h001;
      end
    end
  end
  assign busy = (left != 10'h000) || tickEn;
endmodule
`default_nettype wire

//--- eight_bit_dual_channel_timer_tb.sv
// self-checking bench of the 8-bit dual channel timer
// assumes ebt_tick_src feeds tickEn, flags cleared by flagClr pulses
`include "ebt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module eight_bit_dual_channel_timer_tb;
  import ebt_pkg::*;
  localparam logic [7:0] CTL = `EBT_OFF_CTL;
  localparam logic [7:0] CNT = `EBT_OFF_COUNT;
  logic core_clk, rst, go, tickEn, busy, sfrWrEn, sfrRdEn, tcFlag, irqReq;
  logic [9:0] num;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, e;
  logic [2:0] flagClr;
  logic [1:0] chFlag, chOut, dmaTrig;
  logic [3:0] irqLine;
  int numErrors = 0, checkCount = 0, irqs = 0, dmas = 0, irqBase, dmaBase, m, j, n, k, c;
  ebt_timer dut (.core_clk(core_clk), .rst(rst), .tickEn(tickEn), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .flagClr(flagClr), .tcFlag(tcFlag), .chFlag(chFlag), .irqReq(irqReq),
    .irqLine(irqLine), .chOut(chOut), .dmaTrig(dmaTrig));
  ebt_tick_src src (.core_clk(core_clk), .rst(rst), .num(num), .go(go),
    .tickEn(tickEn), .busy(busy));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (irqReq === 1'b1) irqs++;
    dmas += (dmaTrig[0] === 1'b1) + (dmaTrig[1] === 1'b1);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(posedge core_clk) #1;
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) #1;
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(posedge core_clk) #1;
    sfrRdEn = 1'b0;
    chk(sfrRdData, exp);
  endtask
  task automatic fclr();
    @(posedge core_clk) #1;
    flagClr = 3'h7;
    @(posedge core_clk) #1;
    flagClr = 3'h0;
  endtask
  task automatic ticks(input int t);
    int w;
    w = 0;
    @(posedge core_clk) #1;
    num = t[9:0];
    go = 1'b1;
    @(posedge core_clk) #1;
    go = 1'b0;
    // look at busy off the edge so the tick source has settled
    while (busy !== 1'b0 && w < 4000) begin
      @(posedge core_clk) #1;
      w++;
    end
    if (w == 4000) numErrors++;
  endtask
  task automatic tally_and_finish();
    if (numErrors == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    numErrors++;
    tally_and_finish();
  end
  initial begin
    {rst, go, num, sfrAddr, sfrWrData, sfrWrEn, sfrRdEn, flagClr} = {1'b1, 32'h0};
    k = $urandom(32'h845faa04);
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    chk({4'h0, irqLine}, 8'h0b);
    rd(CTL, `EBT_CTL_RESET);
    rd(`EBT_OFF_CCTL0, `EBT_CCTL_RESET);
    rd(`EBT_OFF_CCTL1, `EBT_CCTL_RESET);
    rd(CNT, 8'h00);
    rd(8'hd0, 8'h00);
    // any run of k<<d ticks holds exactly k active edges, whatever the phase
    for (int d = 0; d < 8; d++) begin
      k = $urandom_range(2, 1);
      wr(CTL, 8'h1c | (d[7:0] << 5));
      rd(CTL, 8'h18 | (d[7:0] << 5));
      ticks(k << d);
      rd(CNT, k[7:0]);
    end
    n = $urandom_range(100, 1);
    wr(CTL, 8'h1c);
    ticks(n);
    wr(CTL, 8'h08);
    ticks(5);
    rd(CNT, n[7:0]);
    wr(CTL, 8'h18);
    ticks(3);
    rd(CNT, n[7:0] + 8'h03);
    fclr();
    irqBase = irqs;
    wr(CTL, 8'h1c);
    ticks(256);
    rd(CNT, 8'h00);
    chk({7'h0, tcFlag}, 8'h01);
    chk(8'(irqs - irqBase), 8'h01);
    ticks(256);
    chk(8'(irqs - irqBase), 8'h01);
    fclr();
    wr(CTL, 8'h14);
    ticks(256);
    chk({7'h0, tcFlag}, 8'h01);
    chk(8'(irqs - irqBase), 8'h01);
    wr(CTL, 8'h18);
    #12;
    chk(8'(irqs - irqBase), 8'h02);
    m = $urandom_range(100, 3);
    j = $urandom_range(m - 1, 1);
    fclr();
    wr(CTL, 8'h0c);
    wr(`EBT_OFF_CC0, m[7:0]);
    wr(CTL, 8'h1e);
    ticks(m);
    rd(CNT, m[7:0]);
    ticks(1);
    rd(CNT, 8'h00);
    chk({7'h0, tcFlag}, 8'h01);
    wr(CTL, 8'h0c);
    wr(CTL, 8'h1f);
    ticks(m + j);
    rd(CNT, m[7:0] - j[7:0]);
    wr(CTL, 8'h1f);
    ticks(2);
    rd(CNT, 8'h02);
    fclr();
    ticks(2 * m - 2);
    rd(CNT, 8'h00);
    chk({7'h0, tcFlag}, 8'h01);
    wr(CTL, 8'h0d);
    fclr();
    wr(CTL, 8'h19);
    rd(CNT, m[7:0]);
    ticks(m);
    rd(CNT, 8'h00);
    chk({7'h0, tcFlag}, 8'h01);
    e = 8'h00;
    for (int a = 0; a < 3; a++) begin
      n = $urandom_range(200, 1);
      wr(CTL, 8'h0c);
      fclr();
      irqBase = irqs;
      dmaBase = dmas;
      wr(`EBT_OFF_CCTL1, 8'h44 | (a[7:0] << 3));
      wr(`EBT_OFF_CC1, n[7:0]);
      wr(CTL, 8'h18);
      ticks(n + 1);
      // dma pulse counts one edge after the match, irq one edge later
      repeat (2) @(posedge core_clk);
      #1;
      e = (a == 0) ? 8'h01 : (a == 1) ? 8'h00 : e ^ 8'h01;
      chk({7'h0, chOut[1]}, e);
      chk({7'h0, chFlag[1]}, 8'h01);
      chk(8'(dmas - dmaBase), 8'h01);
      chk(8'(irqs - irqBase), 8'h01);
    end
    wr(`EBT_OFF_CCTL1, 8'h40);
    // revert actions on channel 0: act at compare, undo at 0xff
    for (int b = 5; b < 7; b++) begin
      c = $urandom_range(200, 1);
      wr(CTL, 8'h0c);
      fclr();
      dmaBase = dmas;
      wr(`EBT_OFF_CC0, c[7:0]);
      wr(`EBT_OFF_CCTL0, 8'h44 | (b[7:0] << 3));
      wr(CTL, 8'h18);
      ticks(c + 1);
      repeat (2) @(posedge core_clk);
      #1;
      chk({7'h0, chOut[0]}, (b == 5) ? 8'h01 : 8'h00);
      chk({7'h0, chFlag[0]}, 8'h01);
      chk(8'(dmas - dmaBase), 8'h01);
      ticks(255 - c);
      rd(CNT, 8'h00);
      chk({7'h0, chOut[0]}, (b == 6) ? 8'h01 : 8'h00);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
